/* File: rtl/rtc_time_date_counters.sv */
// Time and date counter bank with byte-wide register port.
// Assumes a serial front end that decodes addresses, raises access_i
// around each whole burst and pulses wr_en_i per written byte.
`timescale 1ns/100ps
`include "rtc_defs.svh"
module rtc_time_date_counters #(
    parameter int unsigned TICK_CYCLES = `RTC_TICK_CYCLES
) (
    input wire logic clk_i, // System clock
    input wire logic reset_i, // Asynchronous reset, high
    input wire logic access_i, // Serial access in progress
    input wire logic wr_en_i, // Write strobe, one cycle
    input wire logic rd_en_i, // Read strobe, one cycle
    input wire rtc_pkg::rtc_addr_t addr_i, // Register offset
    input wire rtc_pkg::rtc_byte_t wr_data_i, // Write data
    input wire logic hour_12_i, // Hour format, 1 = 12-hour
    output rtc_pkg::rtc_byte_t rd_data_o, // Read data, registered
    output logic rd_valid_o, // Read data valid pulse
    output logic tick_o // Applied advance pulse
);
    import rtc_pkg::*;

    // ************************************************************
    // Tick path
    // ************************************************************
    rtc_tick_if tick_bus ();

    rtc_tick_div #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_div (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .tick_if(tick_bus)
    );

    rtc_tick_hold u_hold (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .access_i(access_i),
        .tick_if(tick_bus)
    );

    // ************************************************************
    // BCD helpers
    // ************************************************************
    function automatic rtc_byte_t bcd_inc(input rtc_byte_t v);
        rtc_byte_t r;
        r = v;
        if (v[3:0] >= 4'h9) begin
            r[3:0] = 4'h0;
            r[7:4] = v[7:4] + 4'h1;
        end else begin
            r[3:0] = v[3:0] + 4'h1;
        end
        return r;
    endfunction

    function automatic rtc_byte_t month_last(input rtc_byte_t mon,
                                              input rtc_byte_t yr);
        rtc_byte_t r;
        logic leap;
        r = 8'h31;
        // BCD year divisible by four: tens even and units 0/4/8, or
        // tens odd and units 2/6; year 00 counts as leap
        leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                     : (yr[1:0] == 2'b00);
        case (mon)
            8'h02: r = leap ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: r = 8'h30;
            default: r = 8'h31;
        endcase
        return r;
    endfunction

    // ************************************************************
    // Counters
    // ************************************************************
    rtc_time_s tm;
    rtc_time_s next_tm;
    logic integrity;
    logic next_integrity;
    logic hour_12_q;

    always_comb begin
        logic c_min;
        logic c_hr;
        logic c_day;
        logic c_mon;
        logic c_yr;
        rtc_byte_t sec_inc;
        rtc_byte_t hr_inc;
        c_min = 1'b0;
        c_hr = 1'b0;
        c_day = 1'b0;
        c_mon = 1'b0;
        c_yr = 1'b0;
        // Function results cannot be part-selected in place
        sec_inc = bcd_inc({1'b0, tm.seconds[6:0]});
        hr_inc = bcd_inc({3'h0, tm.hours[4:0]});
        next_tm = tm;
        next_integrity = integrity;
        if (tick_bus.advance) begin
            // Carry chain, each stage ripples on its own limit
            if (tm.seconds[6:0] == 7'h59) begin
                next_tm.seconds[6:0] = 7'h00;
                c_min = 1'b1;
            end else begin
                next_tm.seconds[6:0] = sec_inc[6:0];
            end
            if (c_min) begin
                if (tm.minutes == 8'h59) begin
                    next_tm.minutes = 8'h00;
                    c_hr = 1'b1;
                end else begin
                    next_tm.minutes = bcd_inc(tm.minutes);
                end
            end
            if (c_hr) begin
                if (hour_12_q) begin
                    // 11 -> 12 flips meridiem and ends the day when leaving PM; 12 -> 1 keeps meridiem
                    if (tm.hours[4:0] == 5'h12) begin
                        next_tm.hours[4:0] = 5'h01;
                    end else if (tm.hours[4:0] == 5'h11) begin
                        next_tm.hours[4:0] = 5'h12;
                        next_tm.hours[`RTC_MERIDIEM_BIT] =
                            ~tm.hours[`RTC_MERIDIEM_BIT];
                        c_day = tm.hours[`RTC_MERIDIEM_BIT];
                    end else begin
                        next_tm.hours[4:0] = hr_inc[4:0];
                    end
                end else if (tm.hours == 8'h23) begin
                    next_tm.hours = 8'h00;
                    c_day = 1'b1;
                end else begin
                    next_tm.hours = bcd_inc(tm.hours);
                end
            end
            if (c_day) begin
                next_tm.weekday = (tm.weekday >= 8'h06) ? 8'h00
                                  : tm.weekday + 8'h01;
                if (tm.days == month_last(tm.month, tm.year)) begin
                    next_tm.days = 8'h01;
                    c_mon = 1'b1;
                end else begin
                    next_tm.days = bcd_inc(tm.days);
                end
            end
            if (c_mon) begin
                if (tm.month == 8'h12) begin
                    next_tm.month = 8'h01;
                    c_yr = 1'b1;
                end else begin
                    next_tm.month = bcd_inc(tm.month);
                end
            end
            if (c_yr) begin
                next_tm.year = (tm.year == 8'h99) ? 8'h00
                               : bcd_inc(tm.year);
            end
        end
        // Writes only occur inside an access, when counting is frozen
        if (wr_en_i) begin
            case (addr_i)
                `RTC_OFS_SECONDS: begin
                    next_tm.seconds = wr_data_i & `RTC_MASK_SECONDS;
                    next_integrity = wr_data_i[`RTC_INTEGRITY_BIT];
                end
                `RTC_OFS_MINUTES: next_tm.minutes =
                    wr_data_i & `RTC_MASK_MINUTES;
                `RTC_OFS_HOURS: next_tm.hours =
                    wr_data_i & `RTC_MASK_HOURS;
                `RTC_OFS_DAYS: next_tm.days =
                    wr_data_i & `RTC_MASK_DAYS;
                `RTC_OFS_WEEKDAY: next_tm.weekday =
                    wr_data_i & `RTC_MASK_WEEKDAY;
                `RTC_OFS_MONTH: next_tm.month =
                    wr_data_i & `RTC_MASK_MONTH;
                `RTC_OFS_YEAR: next_tm.year =
                    wr_data_i & `RTC_MASK_YEAR;
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            tm.seconds <= `RTC_RST_SECONDS;
            tm.minutes <= `RTC_RST_MINUTES;
            tm.hours <= `RTC_RST_HOURS;
            tm.days <= `RTC_RST_DAYS;
            tm.weekday <= `RTC_RST_WEEKDAY;
            tm.month <= `RTC_RST_MONTH;
            tm.year <= `RTC_RST_YEAR;
            integrity <= 1'b1;
            hour_12_q <= 1'b0;
        end else begin
            tm <= next_tm;
            integrity <= next_integrity;
            hour_12_q <= hour_12_i;
        end
    end

    // ************************************************************
    // Read port
    // ************************************************************
    rtc_byte_t next_rd_data;
    rtc_byte_t rd_data_q;
    logic rd_valid_q;
    logic tick_q;

    always_comb begin
        next_rd_data = 8'h00;
        case (addr_i)
            `RTC_OFS_SECONDS: next_rd_data = {integrity,
                                              tm.seconds[6:0]};
            `RTC_OFS_MINUTES: next_rd_data = tm.minutes & `RTC_MASK_MINUTES;
            `RTC_OFS_HOURS: next_rd_data = tm.hours & `RTC_MASK_HOURS;
            `RTC_OFS_DAYS: next_rd_data = tm.days & `RTC_MASK_DAYS;
            `RTC_OFS_WEEKDAY: next_rd_data = tm.weekday & `RTC_MASK_WEEKDAY;
            `RTC_OFS_MONTH: next_rd_data = tm.month & `RTC_MASK_MONTH;
            `RTC_OFS_YEAR: next_rd_data = tm.year;
            default: next_rd_data = 8'h00;
        endcase
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            rd_data_q <= 8'h00;
            rd_valid_q <= 1'b0;
            tick_q <= 1'b0;
        end else begin
            if (rd_en_i) begin
                rd_data_q <= next_rd_data;
            end
            rd_valid_q <= rd_en_i;
            tick_q <= tick_bus.advance;
        end
    end

    assign rd_data_o = rd_data_q;
    assign rd_valid_o = rd_valid_q;
    assign tick_o = tick_q;
endmodule

/* File: rtl/rtc_defs.svh */
// Offsets, field positions, reset values and timing counts of the
// time and date counter bank.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef RTC_DEFS_SVH
`define RTC_DEFS_SVH

`define RTC_OFS_SECONDS 4'h2
`define RTC_OFS_MINUTES 4'h3
`define RTC_OFS_HOURS 4'h4
`define RTC_OFS_DAYS 4'h5
`define RTC_OFS_WEEKDAY 4'h6
`define RTC_OFS_MONTH 4'h7
`define RTC_OFS_YEAR 4'h8

`define RTC_INTEGRITY_BIT 7
`define RTC_MERIDIEM_BIT 5

`define RTC_RST_SECONDS 8'h00
`define RTC_RST_MINUTES 8'h00
`define RTC_RST_HOURS 8'h00
`define RTC_RST_DAYS 8'h01
`define RTC_RST_WEEKDAY 8'h00
`define RTC_RST_MONTH 8'h01
`define RTC_RST_YEAR 8'h00

`define RTC_MASK_SECONDS 8'h7f
`define RTC_MASK_MINUTES 8'h7f
`define RTC_MASK_HOURS 8'h3f
`define RTC_MASK_DAYS 8'h3f
`define RTC_MASK_WEEKDAY 8'h07
`define RTC_MASK_MONTH 8'h1f
`define RTC_MASK_YEAR 8'hff

`define RTC_CLK_HZ 100000000
`define RTC_TICK_HZ 1
`define RTC_TICK_CYCLES (`RTC_CLK_HZ / `RTC_TICK_HZ)

`endif

/* File: rtl/rtc_pkg.sv */
// Types shared by the counter bank and its helpers.
// Assumes rtc_defs.svh supplies the numeric constants.
package rtc_pkg;
    typedef logic [7:0] rtc_byte_t;
    typedef logic [3:0] rtc_addr_t;

    typedef enum logic [1:0] {
        RTC_TICK_IDLE = 2'b00,
        RTC_TICK_HELD = 2'b01,
        RTC_TICK_APPLY = 2'b10
    } rtc_tick_e;

    typedef struct packed {
        rtc_byte_t seconds;
        rtc_byte_t minutes;
        rtc_byte_t hours;
        rtc_byte_t days;
        rtc_byte_t weekday;
        rtc_byte_t month;
        rtc_byte_t year;
    } rtc_time_s;
endpackage

/* File: rtl/rtc_tick_if.sv */
// Tick carrier between the divider, the hold logic and the counters.
// Assumes all parties run on the one system clock.
`timescale 1ns/100ps
interface rtc_tick_if;
    logic tick;
    logic advance;
    modport source (output tick);
    modport sink (input tick);
    modport hold (input tick, output advance);
    modport counter (input advance);
endinterface

/* File: rtl/rtc_tick_div.sv */
// One-second tick divider on the system clock.
// Assumes clk_i at the rate given in rtc_defs.svh; never stops counting.
`timescale 1ns/100ps
`include "rtc_defs.svh"
module rtc_tick_div #(
    parameter int unsigned TICK_CYCLES = `RTC_TICK_CYCLES
) (
    input wire logic clk_i, // System clock
    input wire logic reset_i, // Asynchronous reset, high
    rtc_tick_if.source tick_if // One-cycle second tick
);
    import rtc_pkg::*;

    logic [31:0] count;
    logic [31:0] next_count;
    logic next_tick;
    logic tick_q;

    always_comb begin
        next_count = count + 32'h1;
        next_tick = 1'b0;
        if (count >= TICK_CYCLES - 1) begin
            next_count = 32'h0;
            next_tick = 1'b1;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            count <= 32'h0;
            tick_q <= 1'b0;
        end else begin
            count <= next_count;
            tick_q <= next_tick;
        end
    end

    assign tick_if.tick = tick_q;
endmodule

/* File: rtl/rtc_tick_hold.sv */
// Tick hold: keeps one second tick pending while the host has access.
// Assumes access_i is a same-clock level from the serial front end.
`timescale 1ns/100ps
`include "rtc_defs.svh"
module rtc_tick_hold (
    input wire logic clk_i, // System clock
    input wire logic reset_i, // Asynchronous reset, high
    input wire logic access_i, // Serial access in progress
    rtc_tick_if.hold tick_if // Tick in, advance out
);
    import rtc_pkg::*;

    rtc_tick_e state;
    rtc_tick_e next_state;
    logic next_advance;
    logic advance_q;

    always_comb begin
        next_state = state;
        next_advance = 1'b0;
        case (state)
            RTC_TICK_IDLE: begin
                if (tick_if.tick && access_i) begin
                    next_state = RTC_TICK_HELD;
                end else if (tick_if.tick) begin
                    next_advance = 1'b1;
                end
            end
            RTC_TICK_HELD: begin
                // Only one can be stored; a second tick here is lost
                if (!access_i) begin
                    next_state = RTC_TICK_APPLY;
                end
            end
            RTC_TICK_APPLY: begin
                next_advance = 1'b1;
                next_state = RTC_TICK_IDLE;
                if (access_i) begin
                    next_advance = 1'b0;
                    next_state = RTC_TICK_HELD;
                end
            end
            default: begin
                next_state = RTC_TICK_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            state <= RTC_TICK_IDLE;
            advance_q <= 1'b0;
        end else begin
            state <= next_state;
            advance_q <= next_advance;
        end
    end

    assign tick_if.advance = advance_q;
endmodule

/* File: dv/rtc_tdc_props.sv */
// Concurrent checks on the register port of the counter bank.
// Assumes the bench loads only in-range values and keeps format fixed within each case.
`timescale 1ns/100ps
module rtc_tdc_props import rtc_pkg::*; #(
    parameter int unsigned TICK_CYCLES = 20
) (
    input wire logic clk_i, // System clock
    input wire logic reset_i, // Asynchronous reset, high
    input wire logic access_i, // Access open
    input wire logic wr_en_i, // Write strobe
    input wire logic rd_en_i, // Read strobe
    input wire rtc_addr_t addr_i, // Register offset
    input wire rtc_byte_t wr_data_i, // Write data
    input wire logic hour_12_i, // Hour format
    input wire rtc_byte_t rd_data_o, // Read data
    input wire logic rd_valid_o, // Read valid
    input wire logic tick_o // Applied advance
);
    // ****************************
    // Read tracking
    // ****************************
    rtc_addr_t rd_addr_q, next_rd_addr_q;
    logic flag_q, next_flag_q, rd_flag_q, next_rd_flag_q;
    always_comb begin
        next_rd_addr_q = rd_en_i ? addr_i : rd_addr_q;
        next_rd_flag_q = rd_en_i ? flag_q : rd_flag_q;
        next_flag_q = flag_q;
        if (wr_en_i && addr_i == 4'h2) begin
            next_flag_q = wr_data_i[7];
        end
    end
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            rd_addr_q <= 4'h0;
            flag_q <= 1'b1;
            rd_flag_q <= 1'b1;
        end else begin
            rd_addr_q <= next_rd_addr_q;
            flag_q <= next_flag_q;
            rd_flag_q <= next_rd_flag_q;
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    flag_read_a: assert property (
        rd_valid_o && rd_addr_q == 4'h2 |-> rd_data_o[7] == rd_flag_q)
        else $error("integrity flag wrong");
    sec_range_a: assert property (
        rd_valid_o && rd_addr_q == 4'h2 |->
        rd_data_o[6:4] <= 3'h5 && rd_data_o[3:0] <= 4'h9)
        else $error("seconds out of range");
    min_range_a: assert property (
        rd_valid_o && rd_addr_q == 4'h3 |-> !rd_data_o[7] &&
        rd_data_o[6:4] <= 3'h5 && rd_data_o[3:0] <= 4'h9)
        else $error("minutes out of range");
    hr24_range_a: assert property (
        rd_valid_o && rd_addr_q == 4'h4 && !hour_12_i |->
        rd_data_o <= 8'h23 && rd_data_o[3:0] <= 4'h9)
        else $error("24h hours out of range");
    hr12_range_a: assert property (
        rd_valid_o && rd_addr_q == 4'h4 && hour_12_i |->
        rd_data_o[7:6] == 2'h0 && rd_data_o[4:0] != 5'h00 &&
        rd_data_o[4:0] <= 5'h12 && rd_data_o[3:0] <= 4'h9)
        else $error("12h hours out of range");
    day_range_a: assert property (
        rd_valid_o && rd_addr_q == 4'h5 |-> rd_data_o != 8'h00 &&
        rd_data_o <= 8'h31 && rd_data_o[3:0] <= 4'h9)
        else $error("day out of range");
    wday_range_a: assert property (
        rd_valid_o && rd_addr_q == 4'h6 |-> rd_data_o <= 8'h06)
        else $error("weekday out of range");
    month_range_a: assert property (
        rd_valid_o && rd_addr_q == 4'h7 |-> rd_data_o != 8'h00 &&
        rd_data_o <= 8'h12 && rd_data_o[3:0] <= 4'h9)
        else $error("month out of range");
    year_range_a: assert property (
        rd_valid_o && rd_addr_q == 4'h8 |->
        rd_data_o[7:4] <= 4'h9 && rd_data_o[3:0] <= 4'h9)
        else $error("year out of range");
    unmapped_zero_a: assert property (
        rd_valid_o && (rd_addr_q < 4'h2 || rd_addr_q > 4'h8) |->
        rd_data_o == 8'h00)
        else $error("unmapped read not zero");
    rd_valid_a: assert property (
        rd_en_i |=> rd_valid_o)
        else $error("read valid missing");
    rd_quiet_a: assert property (
        !rd_en_i |=> !rd_valid_o)
        else $error("read valid without read");
    freeze_a: assert property (
        access_i [*5] |-> !tick_o)
        else $error("advance during access");
endmodule
bind rtc_time_date_counters rtc_tdc_props #(.TICK_CYCLES(TICK_CYCLES))
    u_props (.clk_i(clk_i), .reset_i(reset_i), .access_i(access_i),
    .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .addr_i(addr_i),
    .wr_data_i(wr_data_i), .hour_12_i(hour_12_i), .rd_data_o(rd_data_o),
    .rd_valid_o(rd_valid_o), .tick_o(tick_o));

/* File: dv/rtc_host_model.sv */
// Serial host stand-in: opens accesses and moves seven-byte bursts.
// Assumes the bench calls its tasks just after a rising edge.
`timescale 1ns/100ps
module rtc_host_model import rtc_pkg::*; (
    input wire logic clk_i, // System clock
    input wire rtc_byte_t rd_data_i, // Read data
    input wire logic rd_valid_i, // Read valid
    output logic access_o, // Access open
    output logic wr_en_o, // Write strobe
    output logic rd_en_o, // Read strobe
    output rtc_addr_t addr_o, // Register offset
    output rtc_byte_t wr_data_o // Write data
);
    logic acc_q;
    logic wr_q;
    logic rd_q;
    rtc_addr_t addr_q;
    rtc_byte_t data_q;
    assign access_o = acc_q;
    assign wr_en_o = wr_q;
    assign rd_en_o = rd_q;
    assign addr_o = addr_q;
    assign wr_data_o = data_q;
    initial begin
        acc_q = 1'b0;
        wr_q = 1'b0;
        rd_q = 1'b0;
        addr_q = 4'hf;
        data_q = 8'ha5;
    end
    // Bench keeps every access below one second except the one in t_freeze
    task automatic set_acc(input logic a);
        @(posedge clk_i);
        #1;
        acc_q = a;
    endtask
    // Whole field set in one burst
    task automatic wr_burst(input rtc_addr_t a0, input logic [55:0] v);
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_i);
            #1;
            wr_q = (i < 7);
            addr_q = a0 + 4'(i);
            data_q = (i < 7) ? v[8*(6-i) +: 8] : ~data_q;
        end
    endtask
    task automatic rd_burst(input rtc_addr_t a0, output logic [55:0] v,
                            output logic ok);
        ok = 1'b1;
        v = '0;
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_i);
            #1;
            if (i > 0) begin
                ok &= (rd_valid_i === 1'b1);
                v[8*(7-i) +: 8] = rd_data_i;
            end
            rd_q = (i < 7);
            addr_q = a0 + 4'(i);
        end
    endtask
endmodule

/* File: dv/tb_rtc_time_date_counters.sv */
// Self-checking bench for the time and date counter bank.
// Assumes a short divider count so one second is twenty cycles.
`timescale 1ns/100ps
module tb_rtc_time_date_counters;
    import rtc_pkg::*;
    localparam int unsigned TC = 20;
    // In-range loads only; format, loaded fields, fields one tick later
    localparam logic [112:0] CASES [10] = '{
        {1'b0, 56'h59592328060204, 56'h00000029000204},
        {1'b0, 56'h59592328030203, 56'h00000001040303},
        {1'b0, 56'h59592329010200, 56'h00000001020300},
        {1'b0, 56'h59592330050421, 56'h00000001060521},
        {1'b0, 56'h59592331021299, 56'h00000001030100},
        {1'b0, 56'h59091910000721, 56'h00101910000721},
        {1'b0, 56'h09000515030921, 56'h10000515030921},
        {1'b1, 56'h59591115020621, 56'h00003215020621},
        {1'b1, 56'h59593115020621, 56'h00001216030621},
        {1'b1, 56'h59593215020621, 56'h00002115020621}};
    logic clk_i, reset_i, access_i, wr_en_i, rd_en_i, hour_12_i;
    logic rd_valid_o, tick_o, ok;
    rtc_addr_t addr_i;
    rtc_byte_t wr_data_i, rd_data_o;
    logic [55:0] got, snap;
    int fails = 0;
    int compares = 0;
    rtc_time_date_counters #(.TICK_CYCLES(TC)) dut (.clk_i(clk_i),
        .reset_i(reset_i), .access_i(access_i), .wr_en_i(wr_en_i),
        .rd_en_i(rd_en_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
        .hour_12_i(hour_12_i), .rd_data_o(rd_data_o),
        .rd_valid_o(rd_valid_o), .tick_o(tick_o));
    rtc_host_model host (.clk_i(clk_i), .rd_data_i(rd_data_o),
        .rd_valid_i(rd_valid_o), .access_o(access_i), .wr_en_o(wr_en_i),
        .rd_en_o(rd_en_i), .addr_o(addr_i), .wr_data_o(wr_data_i));
    // ****************************
    // Compare and control
    // ****************************
    task automatic cmp_bit(input logic g, input logic e);
        compares++;
        if (g !== e) begin
            fails++;
            $display("mismatch at %0t: flag %b expected %b", $time, g, e);
        end
    endtask
    task automatic cmp_byte(input rtc_byte_t g, input rtc_byte_t e);
        compares++;
        if (g !== e) begin
            fails++;
            $display("mismatch at %0t: byte %h expected %h", $time, g, e);
        end
    endtask
    task automatic cmp_time(input logic [55:0] g, input logic [55:0] e);
        for (int i = 0; i < 7; i++) begin
            cmp_byte(g[8*i +: 8], e[8*i +: 8]);
        end
    endtask
    task automatic wrap_up();
        if (fails == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Bounded wait for the applied advance pulse
    task automatic wait_tick(input int lim);
        int n;
        n = 0;
        do begin
            @(posedge clk_i);
            #1;
            n++;
        end while (tick_o !== 1'b1 && n < lim);
        cmp_bit(tick_o, 1'b1);
    endtask
    task automatic run_case(input logic [112:0] c);
        hour_12_i = c[112];
        wait_tick(60);
        host.set_acc(1'b1);
        host.wr_burst(4'h2, c[111:56]);
        host.set_acc(1'b0);
        wait_tick(60);
        host.set_acc(1'b1);
        host.rd_burst(4'h2, got, ok);
        host.set_acc(1'b0);
        cmp_bit(ok, 1'b1);
        cmp_time(got, c[55:0]);
    endtask
    // ****************************
    // Scenarios
    // ****************************
    task automatic t_reset();
        host.set_acc(1'b1);
        host.rd_burst(4'h2, got, ok);
        cmp_bit(ok, 1'b1);
        cmp_time(got, 56'h80000001000100);
        host.rd_burst(4'h9, got, ok);
        cmp_time(got, 56'h0);
        host.set_acc(1'b0);
        cmp_bit(ok, 1'b1);
    endtask
    // Reset after the flag was cleared must raise it again
    task automatic t_rerun();
        hour_12_i = 1'b0;
        @(posedge clk_i);
        #1;
        reset_i = 1'b1;
        repeat (2) @(posedge clk_i);
        #1;
        reset_i = 1'b0;
        t_reset();
    endtask
    // Two seconds pass inside one access; only one may be applied
    task automatic t_freeze();
        wait_tick(60);
        host.set_acc(1'b1);
        host.rd_burst(4'h2, snap, ok);
        cmp_bit(ok, 1'b1);
        repeat (25) @(posedge clk_i);
        #1;
        host.rd_burst(4'h2, got, ok);
        cmp_time(got, snap);
        host.set_acc(1'b0);
        wait_tick(6);
        host.set_acc(1'b1);
        host.rd_burst(4'h2, got, ok);
        host.set_acc(1'b0);
        cmp_byte(got[55:48], snap[55:48] + 8'h01);
    endtask
    task automatic t_calendar();
        for (int i = 0; i < 7; i++) begin
            run_case(CASES[i]);
        end
    endtask
    task automatic t_twelve();
        for (int i = 7; i < 10; i++) begin
            run_case(CASES[i]);
        end
    endtask
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    initial begin
        reset_i = 1'b1;
        hour_12_i = 1'b0;
        repeat (2) @(posedge clk_i);
        #1;
        reset_i = 1'b0;
        t_reset();
        t_freeze();
        t_calendar();
        t_twelve();
        t_rerun();
        wrap_up();
    end
    // Whole run needs about 500 cycles
    initial begin
        #50000;
        fails++;
        wrap_up();
    end
endmodule
